// ===== rtl/dtc_inc_if.sv
// increment-request bundle between the unit and its source selectors
`timescale 1ns/1ps
`default_nettype none

interface dtc_inc_if;
   logic tick;
   logic run;
   logic gate;
   logic sel_cnt;
   logic req_pin;
   logic cnt_pin;
   logic inc;

   modport ctl (output tick, run, gate, sel_cnt, req_pin, cnt_pin, input inc);
   modport sel (input tick, run, gate, sel_cnt, req_pin, cnt_pin, output inc);
endinterface

`default_nettype wire

// ===== rtl/dtc_pkg.sv
// types shared by the dual timer/counter unit
package dtc_pkg;

   typedef enum logic [1:0]
   {
      DTC_MODE_13    = 2'b00,
      DTC_MODE_16    = 2'b01,
      DTC_MODE_RLD   = 2'b10,
      DTC_MODE_SPLIT = 2'b11
   } dtc_mode_t;

   typedef struct packed
   {
      logic [7:0] low0;
      logic [7:0] high0;
      logic [7:0] low1;
      logic [7:0] high1;
      logic [7:0] ctrl;
      logic [7:0] mode;
      logic [7:0] rdata;
      logic       baud;
      logic [1:0] req_prev;
   } dtc_state_t;

   typedef struct packed
   {
      logic pin_prev;
   } dtc_sel_state_t;

endpackage

// ===== rtl/dtc_regs.svh
// register addresses, field positions, reset values and timing counts
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

// ----------------------------------------------------------------------
// special function register addresses
// ----------------------------------------------------------------------
`define DTC_ADDR_CTRL   8'h88
`define DTC_ADDR_MODE   8'h89
`define DTC_ADDR_LOW0   8'h8A
`define DTC_ADDR_LOW1   8'h8B
`define DTC_ADDR_HIGH0  8'h8C
`define DTC_ADDR_HIGH1  8'h8D

// ----------------------------------------------------------------------
// timer_control bit positions
// ----------------------------------------------------------------------
`define DTC_CTL_TYPE0   0
`define DTC_CTL_EXT0    1
`define DTC_CTL_TYPE1   2
`define DTC_CTL_EXT1    3
`define DTC_CTL_RUN0    4
`define DTC_CTL_OVF0    5
`define DTC_CTL_RUN1    6
`define DTC_CTL_OVF1    7

// ----------------------------------------------------------------------
// timer_mode field positions (counter 0 low nibble, counter 1 high)
// ----------------------------------------------------------------------
`define DTC_MOD_MODE0   1:0
`define DTC_MOD_SEL0    2
`define DTC_MOD_GATE0   3
`define DTC_MOD_MODE1   5:4
`define DTC_MOD_SEL1    6
`define DTC_MOD_GATE1   7

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define DTC_RST_BYTE    8'h00
`define DTC_PRESC_BITS  5
`define DTC_MC_NS       48
`define DTC_CLK_NS      4
`define DTC_TICK_DIV    (`DTC_MC_NS / `DTC_CLK_NS)

`endif

// ===== rtl/dtc_src_sel.sv
// run gating and count-source selection for one counting element
`timescale 1ns/1ps
`default_nettype none

module dtc_src_sel
   import dtc_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic nrst_i,
   dtc_inc_if.sel    port
);

   dtc_sel_state_t st_r;
   dtc_sel_state_t st_nxt;
   logic           fall;
   logic           enable;

   always_comb
   begin
      st_nxt          = st_r;
      st_nxt.pin_prev = port.cnt_pin;
      fall            = st_r.pin_prev & ~port.cnt_pin;
      // pin gating only narrows the run bit, never widens it
      enable          = port.run & (~port.gate | port.req_pin);
      port.inc        = enable & (port.sel_cnt ? fall : port.tick);
   end

   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

endmodule // dtc_src_sel

`default_nettype wire

// ===== rtl/dtc_tick_div.sv
// machine-cycle tick divider
`timescale 1ns/1ps
`default_nettype none
`include "dtc_regs.svh"

module dtc_tick_div
   import dtc_pkg::*;
#(
   parameter int DIV = `DTC_TICK_DIV
)
(
   input  wire logic clock_i,
   input  wire logic nrst_i,
   output var  logic tick_o
);

   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

   typedef struct packed
   {
      logic [CW-1:0] cnt;
      logic          tick;
   } dtc_div_state_t;

   dtc_div_state_t st_r;
   dtc_div_state_t st_nxt;

   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.tick = 1'b0;
      if (st_r.cnt == CW'(DIV - 1))
      begin
         st_nxt.cnt  = '0;
         st_nxt.tick = 1'b1;
      end
      else
      begin
         st_nxt.cnt = st_r.cnt + CW'(1);
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign tick_o = st_r.tick;

endmodule // dtc_tick_div

`default_nettype wire

// ===== rtl/dtc_unit.sv
// dual timer/counter unit: counters, flags and register access
//
// Contract
// - gated counter runs only while request pin high
// - ungated counter runs whenever run bit set
// - source bit picks machine tick or pin
// - mode field selects 13,16,reload,split/stop
// - mode 0: 8 bits behind divide-by-32 prescaler
// - mode 0: high byte bits 12-5, low 4-0
// - mode 0: low byte bits 7-5 undefined
// - mode 1: bytes form one 16-bit counter
// - mode 2: low byte reloads from high byte
// - counter 1 in mode 3 stops counting
// - run bit starts and holds its counter; counter 1 ignores run1 during split
// - split: high0 runs on run1, sets flag1
// - split: low0 uses counter 0 controls
// - each counter 1 overflow pulses serial port
`timescale 1ns/1ps
`default_nettype none
`include "dtc_regs.svh"

module dtc_unit
   import dtc_pkg::*;
#(
   parameter int TICK_DIV = `DTC_TICK_DIV
)
(
   input  wire logic       clock_i,
   input  wire logic       nrst_i,
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic       sfr_wr_i,
   input  wire logic [7:0] sfr_wdata_i,
   input  wire logic       sfr_rd_i,
   output var  logic [7:0] sfr_rdata_o,
   input  wire logic [1:0] external_request_pin_i,
   input  wire logic [1:0] count_pin_i,
   input  wire logic [1:0] ovf_ack_i,
   input  wire logic [1:0] ext_ack_i,
   output var  logic [1:0] ovf_flag_o,
   output var  logic [1:0] ext_flag_o,
   output var  logic       baud_pulse_o
);

   // ----------------------------------------------------------------------
   // state and helpers
   // ----------------------------------------------------------------------
   dtc_state_t st_r;
   dtc_state_t st_nxt;
   logic       tick;
   dtc_mode_t  mode0;
   dtc_mode_t  mode1;
   logic       split0;
   logic       ovf_low0;
   logic       ovf_high0;
   logic       ovf_c1;
   logic [16:0] step0;
   logic [16:0] step1;

   dtc_inc_if inc_low0 ();
   dtc_inc_if inc_high0 ();
   dtc_inc_if inc_c1 ();

   // one increment of a counter pair; returns {overflow, high, low}
   function automatic logic [16:0] count_step(input dtc_mode_t m,
                                              input logic [7:0] hi,
                                              input logic [7:0] lo);
      logic [13:0] c13;
      logic [16:0] c16;
      logic [8:0]  c8;
      logic [16:0] res;
      c13 = 14'({hi, lo[4:0]}) + 14'd1;
      c16 = 17'({hi, lo}) + 17'd1;
      c8  = 9'(lo) + 9'd1;
      res = {1'b0, hi, lo};
      case (m)
         DTC_MODE_13:
         begin
            // upper low-byte bits are left alone and read as junk
            res = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
         end
         DTC_MODE_16:
         begin
            res = c16;
         end
         DTC_MODE_RLD:
         begin
            res = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
         end
         default:
         begin
            // split low byte of counter 0: plain 8-bit counter
            res = {c8[8], hi, c8[7:0]};
         end
      endcase
      return res;
   endfunction

   // ----------------------------------------------------------------------
   // machine tick and source selectors
   // ----------------------------------------------------------------------
   dtc_tick_div #(
      .DIV (TICK_DIV)
   ) u_div (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .tick_o  (tick)
   );

   assign mode0  = dtc_mode_t'(st_r.mode[`DTC_MOD_MODE0]);
   assign mode1  = dtc_mode_t'(st_r.mode[`DTC_MOD_MODE1]);
   assign split0 = (mode0 == DTC_MODE_SPLIT);

   // counter 0 low byte always keeps counter 0's own controls
   assign inc_low0.tick    = tick;
   assign inc_low0.run     = st_r.ctrl[`DTC_CTL_RUN0];
   assign inc_low0.gate    = st_r.mode[`DTC_MOD_GATE0];
   assign inc_low0.sel_cnt = st_r.mode[`DTC_MOD_SEL0];
   assign inc_low0.req_pin = external_request_pin_i[0];
   assign inc_low0.cnt_pin = count_pin_i[0];

   // split high byte: timer only, run by counter 1's run bit
   assign inc_high0.tick    = tick;
   assign inc_high0.run     = split0 & st_r.ctrl[`DTC_CTL_RUN1];
   assign inc_high0.gate    = 1'b0;
   assign inc_high0.sel_cnt = 1'b0;
   assign inc_high0.req_pin = 1'b0;
   assign inc_high0.cnt_pin = 1'b0;

   // run1 is lent out during split, so counter 1 then runs unless in mode 3
   assign inc_c1.tick    = tick;
   assign inc_c1.run     = (mode1 != DTC_MODE_SPLIT)
                           & (split0 | st_r.ctrl[`DTC_CTL_RUN1]);
   assign inc_c1.gate    = st_r.mode[`DTC_MOD_GATE1];
   assign inc_c1.sel_cnt = st_r.mode[`DTC_MOD_SEL1];
   assign inc_c1.req_pin = external_request_pin_i[1];
   assign inc_c1.cnt_pin = count_pin_i[1];

   dtc_src_sel u_sel_low0 (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .port    (inc_low0.sel)
   );

   dtc_src_sel u_sel_high0 (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .port    (inc_high0.sel)
   );

   dtc_src_sel u_sel_c1 (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .port    (inc_c1.sel)
   );

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      st_nxt    = st_r;
      ovf_low0  = 1'b0;
      ovf_high0 = 1'b0;
      ovf_c1    = 1'b0;
      step0     = count_step(mode0, st_r.high0, st_r.low0);
      step1     = count_step(mode1, st_r.high1, st_r.low1);

      // counting; split mode keeps the high byte out of counter 0's step
      if (inc_low0.inc)
      begin
         ovf_low0     = step0[16];
         st_nxt.low0  = step0[7:0];
         if (!split0)
            st_nxt.high0 = step0[15:8];
      end
      if (inc_high0.inc)
      begin
         ovf_high0    = &st_r.high0;
         st_nxt.high0 = st_r.high0 + 8'd1;
      end
      if (inc_c1.inc)
      begin
         ovf_c1       = step1[16];
         st_nxt.high1 = step1[15:8];
         st_nxt.low1  = step1[7:0];
      end

      // software writes to count bytes win over a same-cycle increment;
      // the prescaler is not cleared for the caller
      if (sfr_wr_i)
      begin
         case (sfr_addr_i)
            `DTC_ADDR_LOW0:  st_nxt.low0  = sfr_wdata_i;
            `DTC_ADDR_HIGH0: st_nxt.high0 = sfr_wdata_i;
            `DTC_ADDR_LOW1:  st_nxt.low1  = sfr_wdata_i;
            `DTC_ADDR_HIGH1: st_nxt.high1 = sfr_wdata_i;
            `DTC_ADDR_MODE:  st_nxt.mode  = sfr_wdata_i;
            `DTC_ADDR_CTRL:  st_nxt.ctrl  = sfr_wdata_i;
            default:         st_nxt.mode  = st_r.mode;
         endcase
      end

      // flags: acknowledge clears, then write, then hardware set wins
      if (ovf_ack_i[0] && !(sfr_wr_i && sfr_addr_i == `DTC_ADDR_CTRL))
         st_nxt.ctrl[`DTC_CTL_OVF0] = 1'b0;
      if (ovf_ack_i[1] && !(sfr_wr_i && sfr_addr_i == `DTC_ADDR_CTRL))
         st_nxt.ctrl[`DTC_CTL_OVF1] = 1'b0;
      if (ovf_low0)
         st_nxt.ctrl[`DTC_CTL_OVF0] = 1'b1;
      // during split counter 1 gives up its flag to the high byte
      if (ovf_high0 || (ovf_c1 && !split0))
         st_nxt.ctrl[`DTC_CTL_OVF1] = 1'b1;

      // external request flags
      st_nxt.req_prev = external_request_pin_i;
      for (int i = 0; i < 2; i++)
      begin
         if (st_r.ctrl[`DTC_CTL_TYPE0 + 2 * i])
         begin
            if (ext_ack_i[i] && !(sfr_wr_i && sfr_addr_i == `DTC_ADDR_CTRL))
               st_nxt.ctrl[`DTC_CTL_EXT0 + 2 * i] = 1'b0;
            if (st_r.req_prev[i] && !external_request_pin_i[i])
               st_nxt.ctrl[`DTC_CTL_EXT0 + 2 * i] = 1'b1;
         end
         else
         begin
            // level type tracks the pin; acknowledge has no effect
            st_nxt.ctrl[`DTC_CTL_EXT0 + 2 * i] = ~external_request_pin_i[i];
         end
      end

      st_nxt.baud = ovf_c1;

      // registered read data, one cycle after the strobe
      st_nxt.rdata = `DTC_RST_BYTE;
      if (sfr_rd_i)
      begin
         case (sfr_addr_i)
            `DTC_ADDR_CTRL:  st_nxt.rdata = st_r.ctrl;
            `DTC_ADDR_MODE:  st_nxt.rdata = st_r.mode;
            `DTC_ADDR_LOW0:  st_nxt.rdata = st_r.low0;
            `DTC_ADDR_HIGH0: st_nxt.rdata = st_r.high0;
            `DTC_ADDR_LOW1:  st_nxt.rdata = st_r.low1;
            `DTC_ADDR_HIGH1: st_nxt.rdata = st_r.high1;
            default:         st_nxt.rdata = `DTC_RST_BYTE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st_r          <= '0;
         st_r.req_prev <= 2'h3;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign sfr_rdata_o   = st_r.rdata;
   assign ovf_flag_o    = {st_r.ctrl[`DTC_CTL_OVF1], st_r.ctrl[`DTC_CTL_OVF0]};
   assign ext_flag_o    = {st_r.ctrl[`DTC_CTL_EXT1], st_r.ctrl[`DTC_CTL_EXT0]};
   assign baud_pulse_o  = st_r.baud;

endmodule // dtc_unit

`default_nettype wire

// ===== testbench/dtc_irq_model.sv
// interrupt logic model: vectors to each raised flag after a delay
`timescale 1ns/1ps
`default_nettype none

module dtc_irq_model
(
   input  wire logic       clock_i,
   input  wire logic       nrst_i,
   input  wire logic [3:0] flag_i,
   input  wire logic [3:0] dly_i,
   output var  logic [3:0] ack_o
);
   logic [3:0] cnt_r [4];
   logic [3:0] done_r;

   // one ack per raised flag; a level flag that stays up is not re-acked
   always @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ack_o  <= 4'h0;
         done_r <= 4'h0;
         for (int i = 0; i < 4; i++)
            cnt_r[i] <= 4'h0;
      end
      else
         for (int i = 0; i < 4; i++)
         begin
            ack_o[i] <= 1'b0;
            if (flag_i[i] !== 1'b1)
            begin
               cnt_r[i]  <= 4'h0;
               done_r[i] <= 1'b0;
            end
            else if (!done_r[i] && cnt_r[i] == dly_i)
            begin
               ack_o[i]  <= 1'b1;
               done_r[i] <= 1'b1;
            end
            else if (!done_r[i])
               cnt_r[i] <= cnt_r[i] + 4'h1;
         end
   end
endmodule // dtc_irq_model

`default_nettype wire

// ===== testbench/dtc_unit_monitor.sv
// port checker for the dual timer/counter unit
`timescale 1ns/1ps
`default_nettype none
`include "dtc_regs.svh"

module dtc_unit_monitor
#(
   parameter int TICK_DIV = 12
)
(
   input wire logic       clock_i,
   input wire logic       nrst_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic       sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic       sfr_rd_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic [1:0] external_request_pin_i,
   input wire logic [1:0] count_pin_i,
   input wire logic [1:0] ovf_ack_i,
   input wire logic [1:0] ext_ack_i,
   input wire logic [1:0] ovf_flag_o,
   input wire logic [1:0] ext_flag_o,
   input wire logic       baud_pulse_o
);
   // ----
   // shadows of software-only fields
   // ----
   logic [7:0] mode_r;
   logic [1:0] run_r;
   logic [3:0] flg;
   logic       split;

   assign flg   = {ovf_flag_o[1], ovf_flag_o[0], ext_flag_o[1], ext_flag_o[0]};
   assign split = mode_r[1:0] == 2'b11;

   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         mode_r <= 8'h00;
         run_r  <= 2'h0;
      end
      else if (sfr_wr_i)
      begin
         if (sfr_addr_i == `DTC_ADDR_MODE)
            mode_r <= sfr_wdata_i;
         if (sfr_addr_i == `DTC_ADDR_CTRL)
            run_r <= {sfr_wdata_i[`DTC_CTL_RUN1], sfr_wdata_i[`DTC_CTL_RUN0]};
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   // a write in the wrap cycle cannot clear the flag, since the hardware set wins, but is still excluded
   sequence s_wrap;
      baud_pulse_o && !$past(sfr_wr_i) && $past(mode_r[1:0]) != 2'b11;
   endsequence
   property p_flag_baud;
      s_wrap |-> ovf_flag_o[1];
   endproperty
   a_flag_baud: assert property (p_flag_baud) else $error("baud pulse without flag");
   property p_ctrl_flags;
      sfr_rd_i && sfr_addr_i == `DTC_ADDR_CTRL |=> {sfr_rdata_o[7], sfr_rdata_o[5],
         sfr_rdata_o[3], sfr_rdata_o[1]} == $past(flg);
   endproperty
   a_ctrl_flags: assert property (p_ctrl_flags) else $error("control read flags");
   property p_stopped;
      !run_r[0] && !run_r[1] && !sfr_wr_i |=> !$rose(ovf_flag_o[0]) && !$rose(ovf_flag_o[1]);
   endproperty
   a_stopped: assert property (p_stopped) else $error("flag rose while stopped");
   property p_ovf_ack;
      ovf_ack_i[0] && !sfr_wr_i && !run_r[0] |=> !ovf_flag_o[0];
   endproperty
   a_ovf_ack: assert property (p_ovf_ack) else $error("overflow ack ignored");
   property p_ext_ack;
      ext_ack_i[0] && external_request_pin_i[0] && !sfr_wr_i |=> !ext_flag_o[0];
   endproperty
   a_ext_ack: assert property (p_ext_ack) else $error("request ack ignored");
   property p_baud_single;
      baud_pulse_o |=> !baud_pulse_o;
   endproperty
   a_baud_single: assert property (p_baud_single) else $error("baud pulse too long");
   property p_stop_mode;
      mode_r[5:4] == 2'b11 |=> !baud_pulse_o;
   endproperty
   a_stop_mode: assert property (p_stop_mode) else $error("stopped counter wrapped");
   property p_run_hold;
      !run_r[1] && !split |=> !baud_pulse_o;
   endproperty
   a_run_hold: assert property (p_run_hold) else $error("held counter wrapped");
   // pin gates the increment unregistered, so one low sample would do; two are still required
   property p_gate_hold;
      mode_r[7] && !split && !external_request_pin_i[1] && !$past(external_request_pin_i[1])
         |=> !baud_pulse_o;
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("gated counter wrapped");
endmodule // dtc_unit_monitor

bind dtc_unit dtc_unit_monitor #(.TICK_DIV(TICK_DIV)) u_mon
(
   .clock_i, .nrst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o,
   .external_request_pin_i, .count_pin_i, .ovf_ack_i, .ext_ack_i, .ovf_flag_o,
   .ext_flag_o, .baud_pulse_o
);

`default_nettype wire

// ===== testbench/dtc_unit_tb.sv
// self-checking bench for the dual timer/counter unit
`timescale 1ns/1ps
`default_nettype none
`include "dtc_regs.svh"

module dtc_unit_tb
   import dtc_pkg::*;
;
   localparam int TD = 2;
   logic            clk       = 1'b0;
   logic            nrst      = 1'b0;
   logic [7:0]      sfr_addr  = 8'h00;
   logic [7:0]      sfr_wdata = 8'h00;
   logic            sfr_wr    = 1'b0;
   logic            sfr_rd    = 1'b0;
   logic [1:0]      req_pin   = 2'h3;
   logic [1:0]      cnt_pin   = 2'h0;
   logic [3:0]      dly       = 4'h1;
   wire logic [7:0] rdata;
   wire logic [1:0] ovf_flag;
   wire logic [1:0] ext_flag;
   wire logic [1:0] ovf_ack;
   wire logic [1:0] ext_ack;
   wire logic       baud;
   logic [3:0]      flags;
   int              failures  = 0;
   int              cmp_count = 0;
   int              cycles    = 0;

   assign flags = {ext_flag, ovf_flag};
   always #2 clk = ~clk;

   dtc_unit #(.TICK_DIV(TD)) uut
   (
      .clock_i(clk), .nrst_i(nrst), .sfr_addr_i(sfr_addr), .sfr_wr_i(sfr_wr),
      .sfr_wdata_i(sfr_wdata), .sfr_rd_i(sfr_rd), .sfr_rdata_o(rdata),
      .external_request_pin_i(req_pin), .count_pin_i(cnt_pin), .ovf_ack_i(ovf_ack),
      .ext_ack_i(ext_ack), .ovf_flag_o(ovf_flag), .ext_flag_o(ext_flag), .baud_pulse_o(baud)
   );
   dtc_irq_model u_irq
   (
      .clock_i(clk), .nrst_i(nrst), .flag_i(flags), .dly_i(dly), .ack_o({ext_ack, ovf_ack})
   );

   // ----
   // access and compare tasks
   // ----
   task automatic finish_test;
      if (failures == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
      cmp_count++;
      if ((got & msk) !== (exp & msk))
      begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_addr  <= a;
      sfr_wdata <= d;
      sfr_wr    <= 1'b1;
      @(posedge clk);
      sfr_wr    <= 1'b0;
   endtask

   task automatic read_chk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd   <= 1'b1;
      @(posedge clk);
      sfr_rd   <= 1'b0;
      #1;
      chk8(rdata, exp, msk);
   endtask

   // bounded poll; a flag may stand only a few cycles before the ack
   task automatic wait_bit(input int i, input logic v);
      int n;
      n = 0;
      #1;
      while (flags[i] !== v && n < 300)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk8({7'h00, flags[i]}, {7'h00, v}, 8'h01);
   endtask

   task automatic wait_baud(output int n);
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (baud !== 1'b1 && n < 300);
   endtask

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         failures = failures + 1;
         finish_test;
      end
   end

   // ----
   // scenarios
   // ----
   initial
   begin
      int         n;
      logic [7:0] mtab [3];
      logic [7:0] etab [3];
      logic [2:0] ptab;
      mtab = '{8'h90, 8'h90, 8'h10};
      etab = '{8'h00, 8'h0B, 8'h0B};
      ptab = 3'b010;
      cyc(12);
      nrst <= 1'b1;
      for (logic [8:0] a = 9'h088; a <= 9'h08E; a++)
         read_chk(a[7:0], 8'h00, 8'hFF);
      write_reg(`DTC_ADDR_MODE, 8'h01);
      write_reg(`DTC_ADDR_LOW0, 8'hFE);
      write_reg(`DTC_ADDR_HIGH0, 8'h12);
      write_reg(`DTC_ADDR_CTRL, 8'h10);
      cyc(38);
      write_reg(`DTC_ADDR_CTRL, 8'h00);
      read_chk(`DTC_ADDR_HIGH0, 8'h13, 8'hFF);
      read_chk(`DTC_ADDR_LOW0, 8'h12, 8'hFF);
      write_reg(`DTC_ADDR_MODE, 8'h00);
      write_reg(`DTC_ADDR_HIGH0, 8'h00);
      write_reg(`DTC_ADDR_LOW0, 8'h00);
      write_reg(`DTC_ADDR_CTRL, 8'h10);
      cyc(70);
      write_reg(`DTC_ADDR_CTRL, 8'h00);
      read_chk(`DTC_ADDR_HIGH0, 8'h01, 8'hFF);
      read_chk(`DTC_ADDR_LOW0, 8'h04, 8'h1F);
      write_reg(`DTC_ADDR_MODE, 8'h20);
      write_reg(`DTC_ADDR_HIGH1, 8'hF0);
      write_reg(`DTC_ADDR_LOW1, 8'hF0);
      write_reg(`DTC_ADDR_CTRL, 8'h40);
      wait_baud(n);
      wait_baud(n);
      chk8(8'(n), 8'(16 * TD), 8'hFF);
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk);
         req_pin[1] <= ptab[i];
         write_reg(`DTC_ADDR_MODE, mtab[i]);
         write_reg(`DTC_ADDR_LOW1, 8'h00);
         write_reg(`DTC_ADDR_HIGH1, 8'h00);
         write_reg(`DTC_ADDR_CTRL, 8'h40);
         cyc(20);
         write_reg(`DTC_ADDR_CTRL, 8'h00);
         read_chk(`DTC_ADDR_LOW1, etab[i], 8'hFF);
      end
      @(posedge clk);
      req_pin <= 2'h3;
      write_reg(`DTC_ADDR_MODE, 8'h55);
      write_reg(`DTC_ADDR_LOW0, 8'h00);
      write_reg(`DTC_ADDR_LOW1, 8'h00);
      write_reg(`DTC_ADDR_CTRL, 8'h50);
      repeat (5)
      begin
         cyc(2);
         cnt_pin <= 2'h3;
         cyc(2);
         cnt_pin <= 2'h0;
      end
      write_reg(`DTC_ADDR_CTRL, 8'h00);
      read_chk(`DTC_ADDR_LOW0, 8'h05, 8'hFF);
      read_chk(`DTC_ADDR_LOW1, 8'h05, 8'hFF);
      write_reg(`DTC_ADDR_MODE, 8'h30);
      write_reg(`DTC_ADDR_LOW1, 8'h00);
      write_reg(`DTC_ADDR_CTRL, 8'h40);
      cyc(20);
      read_chk(`DTC_ADDR_LOW1, 8'h00, 8'hFF);
      write_reg(`DTC_ADDR_MODE, 8'h33);
      write_reg(`DTC_ADDR_HIGH0, 8'hFE);
      write_reg(`DTC_ADDR_LOW0, 8'hFE);
      wait_bit(1, 1'b1);
      read_chk(`DTC_ADDR_LOW0, 8'hFE, 8'hFF);
      write_reg(`DTC_ADDR_CTRL, 8'h10);
      wait_bit(0, 1'b1);
      dly <= 4'hC;
      write_reg(`DTC_ADDR_CTRL, 8'h20);
      read_chk(`DTC_ADDR_CTRL, 8'h20, 8'hFF);
      wait_bit(0, 1'b0);
      @(posedge clk);
      dly <= 4'h1;
      write_reg(`DTC_ADDR_CTRL, 8'h05);
      cyc(2);
      req_pin[0] <= 1'b0;
      cyc(1);
      req_pin[0] <= 1'b1;
      wait_bit(2, 1'b1);
      wait_bit(2, 1'b0);
      cyc(4);
      wait_bit(2, 1'b0);
      write_reg(`DTC_ADDR_CTRL, 8'h00);
      req_pin[0] <= 1'b0;
      cyc(8);
      wait_bit(2, 1'b1);
      @(posedge clk);
      req_pin[0] <= 1'b1;
      wait_bit(2, 1'b0);
      finish_test;
   end
endmodule // dtc_unit_tb

`default_nettype wire
